// ---- pmc_defines.svh ----
// constants for the management-bus slave with nonvolatile load
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
`define PMC_ADDR_BASE 7'h21
`define PMC_STRAP_MAX 3'h6
`define PMC_RETRY_MAX 2'h2
`define PMC_BUS_FREE_NS 4700
`define PMC_CLK_NS 20
`define PMC_BUS_FREE_CYC ((`PMC_BUS_FREE_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`define PMC_VSET_REG 8'h21
`define PMC_VSET_DEFAULT 8'h32
`define PMC_CML_BIT 1
`define PMC_MFR_OTP_BIT 0
`endif

// ---- pmc_pkg.sv ----
// types for the management-bus slave with nonvolatile load
package pmc_pkg;
    typedef struct packed {
        logic [3:0] vref_code;
        logic [3:0] div_code;
    } pmc_vcfg_t;
    typedef struct packed {
        logic [7:0] status_byte;
        logic [15:0] status_word;
        logic [7:0] status_mfr;
    } pmc_status_t;
endpackage

// ---- pmc_top.sv ----
// management-bus slave, output-voltage lookup and checked nonvolatile load
`timescale 1ns/1ns
`include "pmc_defines.svh"
// Behaviour
// - slave logic sampled on the bus clock, so fast and high-speed rates both work
// - data sampled on clock rise, driven only after clock fall
// - busy from start to stop; repeated start acts as start; free after idle time
// - eight bits then acknowledge; line released when not acknowledging
// - first byte is seven address bits plus direction bit
// - drive data low through acknowledge clock after every accepted byte
// - select only on address match
// - commit value at falling clock of the data byte's last bit
// - address from seven strap settings, consecutive from the base
// - enabled start uses default setting, then bus is accepted
// - valid setting looked up into reference and divider codes
// - check every nonvolatile load with a checksum
// - on error retry page twice more, then move to next page
// - no valid page sets fault bits and pulls alert low
// - enable low holds regulator and bus logic off
module pmc_top import pmc_pkg::*; #(
    parameter int PAGES = 4
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic en_pin,
    input wire logic uvlo_ok,
    input wire logic [2:0] addr_strap,
    input wire logic bus_clk,
    input wire logic bus_data_in,
    output logic bus_data_out,
    output logic bus_data_oe,
    output logic nvm_rd,
    output logic [1:0] nvm_page,
    input wire logic nvm_done,
    input wire logic nvm_crc_ok,
    input wire logic [1:0] nvm_avail_n,
    output pmc_vcfg_t vcfg,
    output pmc_status_t status,
    output logic fault_alert_line_n,
    output logic reg_on,
    output logic bus_free
);
    // ************************************************************
    // enable synchroniser (system domain)
    // ************************************************************
    logic run_n;
    assign run_n = rstn & en_pin;
    logic [1:0] en_s_q;
    always_ff @(posedge clk_sys or negedge run_n) begin
        if (!run_n) begin
            en_s_q <= 2'h0;
        end else begin
            en_s_q <= {en_s_q[0], uvlo_ok};
        end
    end
    // ************************************************************
    // nonvolatile handshake synchronisers
    // ************************************************************
    // checksum verdict pin, aligned with the second done stage
    logic [1:0] crc_s_q;
    always_ff @(posedge clk_sys or negedge run_n) begin
        if (!run_n) begin
            crc_s_q <= 2'h0;
        end else begin
            crc_s_q <= {crc_s_q[0], nvm_crc_ok};
        end
    end
    typedef enum logic [2:0] {LD_IDLE, LD_READ, LD_WAIT, LD_OK, LD_FAIL} pmc_ld_t;
    pmc_ld_t ld_q;
    logic [1:0] try_q;
    logic [1:0] page_q;
    logic done_s1_q, done_s2_q, done_s3_q;
    always_ff @(posedge clk_sys or negedge run_n) begin
        if (!run_n) begin
            done_s1_q <= 1'b0;
            done_s2_q <= 1'b0;
            done_s3_q <= 1'b0;
        end else begin
            done_s1_q <= nvm_done;
            done_s2_q <= done_s1_q;
            done_s3_q <= done_s2_q;
        end
    end
    logic done_rise;
    assign done_rise = done_s2_q & ~done_s3_q;
    always_ff @(posedge clk_sys or negedge run_n) begin
        if (!run_n) begin
            ld_q <= LD_IDLE;
            try_q <= 2'h0;
            page_q <= 2'h0;
            nvm_rd <= 1'b0;
        end else begin
            case (ld_q)
                LD_IDLE: if (en_s_q[1]) begin
                    ld_q <= LD_READ;
                end
                LD_READ: begin
                    nvm_rd <= 1'b1;
                    ld_q <= LD_WAIT;
                end
                LD_WAIT: if (done_rise) begin
                    nvm_rd <= 1'b0;
                    if (crc_s_q[1]) begin
                        ld_q <= LD_OK;
                    end else if (try_q != `PMC_RETRY_MAX) begin
                        try_q <= try_q + 2'h1;
                        ld_q <= LD_READ;
                    end else if (page_q != 2'(PAGES - 1)) begin
                        try_q <= 2'h0;
                        page_q <= page_q + 2'h1;
                        ld_q <= LD_READ;
                    end else begin
                        ld_q <= LD_FAIL;
                    end
                end
                LD_OK: begin
                    ld_q <= LD_OK;
                end
                LD_FAIL: begin
                    ld_q <= LD_FAIL;
                end
                default: ld_q <= LD_IDLE;
            endcase
        end
    end
    assign nvm_page = page_q;
    logic fail_q;
    // registered so the bus-side synchroniser never sees a decode glitch
    logic up_q;
    always_ff @(posedge clk_sys or negedge run_n) begin
        if (!run_n) begin
            up_q <= 1'b0;
        end else begin
            up_q <= (ld_q == LD_OK) || fail_q;
        end
    end
    always_ff @(posedge clk_sys or negedge run_n) begin
        if (!run_n) begin
            fail_q <= 1'b0;
            status <= '0;
            fault_alert_line_n <= 1'b1;
            reg_on <= 1'b0;
        end else begin
            reg_on <= en_s_q[1];
            if (ld_q == LD_FAIL) begin
                fail_q <= 1'b1;
                status.status_byte[`PMC_CML_BIT] <= 1'b1;
                status.status_word[`PMC_CML_BIT] <= 1'b1;
                status.status_mfr[`PMC_MFR_OTP_BIT] <= 1'b1;
                fault_alert_line_n <= 1'b0;
            end
        end
    end
    function automatic pmc_vcfg_t vlookup(input logic [7:0] v);
        pmc_vcfg_t c;
        c.vref_code = (v < 8'h20) ? 4'h0 : (v < 8'h40) ? 4'h1 : 4'h2;
        c.div_code = v[3:0];
        return c;
    endfunction
    localparam pmc_vcfg_t VCFG_RST = vlookup(`PMC_VSET_DEFAULT);
    // ************************************************************
    // bus side (bus clock domain)
    // ************************************************************
    // bus clock idles between frames, so readiness is judged at the address byte
    logic [1:0] ready_s_q;
    always_ff @(posedge bus_clk or negedge run_n) begin
        if (!run_n) begin
            ready_s_q <= 2'h0;
        end else begin
            ready_s_q <= {ready_s_q[0], up_q};
        end
    end
    // strap pins settle through two bus-clock stages before the compare
    logic [2:0] strap_s1_q;
    logic [2:0] strap_s2_q;
    always_ff @(posedge bus_clk or negedge run_n) begin
        if (!run_n) begin
            strap_s1_q <= 3'h0;
            strap_s2_q <= 3'h0;
        end else begin
            strap_s1_q <= addr_strap;
            strap_s2_q <= strap_s1_q;
        end
    end
    logic start_tg_q, stop_tg_q;
    logic [6:0] own_addr;
    assign own_addr = `PMC_ADDR_BASE + 7'((strap_s2_q > `PMC_STRAP_MAX) ?
        `PMC_STRAP_MAX : strap_s2_q);
    // ************************************************************
    // start and stop seen on data edges while clock is high
    // ************************************************************
    always_ff @(negedge bus_data_in or negedge run_n) begin
        if (!run_n) begin
            start_tg_q <= 1'b0;
        end else if (bus_clk) begin
            start_tg_q <= ~start_tg_q;
        end
    end
    always_ff @(posedge bus_data_in or negedge run_n) begin
        if (!run_n) begin
            stop_tg_q <= 1'b0;
        end else if (bus_clk) begin
            stop_tg_q <= ~stop_tg_q;
        end
    end
    // ************************************************************
    // byte receiver (bus clock domain)
    // ************************************************************
    logic st_seen_q, sp_seen_q;
    typedef enum logic [2:0] {BS_IDLE, BS_ADDR, BS_REG, BS_DATA, BS_IGN} pmc_bs_t;
    pmc_bs_t bs_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] reg_q;
    logic ack_pend_q;
    logic commit_q;
    // set only by a received data byte, so a register byte never commits
    logic dack_q;
    logic [7:0] data_q;
    always_ff @(posedge bus_clk or negedge run_n) begin
        if (!run_n) begin
            st_seen_q <= 1'b0;
            sp_seen_q <= 1'b0;
            bs_q <= BS_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            reg_q <= 8'h00;
            ack_pend_q <= 1'b0;
            dack_q <= 1'b0;
            data_q <= 8'h00;
        end else begin
            st_seen_q <= start_tg_q;
            sp_seen_q <= stop_tg_q;
            if (st_seen_q != start_tg_q) begin
                bs_q <= BS_ADDR;
                bit_q <= 4'h1;
                sh_q <= {7'h00, bus_data_in};
                ack_pend_q <= 1'b0;
                dack_q <= 1'b0;
            end else if (sp_seen_q != stop_tg_q) begin
                bs_q <= BS_IDLE;
                bit_q <= 4'h0;
            end else if (bs_q != BS_IDLE && bs_q != BS_IGN) begin
                if (bit_q == 4'h8) begin
                    bit_q <= 4'h0;
                    ack_pend_q <= 1'b0;
                    dack_q <= 1'b0;
                end else begin
                    sh_q <= {sh_q[6:0], bus_data_in};
                    bit_q <= bit_q + 4'h1;
                    if (bit_q == 4'h7) begin
                        case (bs_q)
                            BS_ADDR: begin
                                if (sh_q[6:0] == own_addr && !bus_data_in
                                    && ready_s_q[1]) begin
                                    bs_q <= BS_REG;
                                    ack_pend_q <= 1'b1;
                                end else begin
                                    bs_q <= BS_IGN;
                                end
                            end
                            BS_REG: begin
                                reg_q <= {sh_q[6:0], bus_data_in};
                                bs_q <= BS_DATA;
                                ack_pend_q <= 1'b1;
                            end
                            BS_DATA: begin
                                data_q <= {sh_q[6:0], bus_data_in};
                                dack_q <= 1'b1;
                                ack_pend_q <= 1'b1;
                            end
                            default: bs_q <= BS_IGN;
                        endcase
                    end
                end
            end
        end
    end
    // ************************************************************
    // drive and commit on falling clock edge
    // ************************************************************
    always_ff @(negedge bus_clk or negedge run_n) begin
        if (!run_n) begin
            bus_data_out <= 1'b1;
            bus_data_oe <= 1'b0;
            commit_q <= 1'b0;
        end else begin
            bus_data_oe <= ack_pend_q && bit_q == 4'h8;
            bus_data_out <= 1'b0;
            if (dack_q && bit_q == 4'h8 && reg_q == `PMC_VSET_REG) begin
                commit_q <= ~commit_q;
            end
        end
    end
    // ************************************************************
    // output setting (system domain)
    // ************************************************************
    logic [2:0] cm_s_q;
    always_ff @(posedge clk_sys or negedge run_n) begin
        if (!run_n) begin
            cm_s_q <= 3'h0;
            vcfg <= VCFG_RST;
        end else begin
            cm_s_q <= {cm_s_q[1:0], commit_q};
            if (cm_s_q[2] != cm_s_q[1]) vcfg <= vlookup(data_q);
        end
    end
    // ************************************************************
    // bus-free timer (system domain)
    // ************************************************************
    logic [2:0] sp_s_q;
    logic [2:0] st_s_q;
    logic [8:0] idle_q;
    always_ff @(posedge clk_sys or negedge run_n) begin
        if (!run_n) begin
            sp_s_q <= 3'h0;
            st_s_q <= 3'h0;
            idle_q <= 9'h000;
            bus_free <= 1'b1;
        end else begin
            sp_s_q <= {sp_s_q[1:0], stop_tg_q};
            st_s_q <= {st_s_q[1:0], start_tg_q};
            if (st_s_q[2] != st_s_q[1]) begin
                bus_free <= 1'b0;
                idle_q <= 9'h000;
            end else if (sp_s_q[2] != sp_s_q[1]) begin
                idle_q <= 9'h001;
            end else if (idle_q != 9'h000) begin
                if (idle_q == 9'(`PMC_BUS_FREE_CYC)) begin
                    bus_free <= 1'b1;
                    idle_q <= 9'h000;
                end else begin
                    idle_q <= idle_q + 9'h001;
                end
            end
        end
    end
endmodule

// ---- pmc_sva.sv ----
// concurrent checks on the slave's ports
`timescale 1ns/1ns
`include "pmc_defines.svh"
module pmc_sva import pmc_pkg::*; (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic en_pin,
    input wire logic bus_clk,
    input wire logic bus_data_out,
    input wire logic bus_data_oe,
    input wire logic nvm_rd,
    input wire logic [1:0] nvm_page,
    input wire pmc_vcfg_t vcfg,
    input wire pmc_status_t status,
    input wire logic fault_alert_line_n,
    input wire logic reg_on,
    input wire logic bus_free
);
    // ********
    // helper count and sequence
    // ********
    logic [8:0] low_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) low_q <= 9'h000;
        else if (bus_free) low_q <= 9'h000;
        else if (low_q != 9'h1ff) low_q <= low_q + 9'h001;
    end
    sequence ack_pulse;
        bus_data_oe ##1 !bus_data_oe;
    endsequence
    ack_once_a: assert property (@(negedge bus_clk) disable iff (!rstn || !en_pin)
        $rose(bus_data_oe) |-> ack_pulse) else $error("ack not one bit long");
    ack_level_a: assert property (@(posedge bus_clk) disable iff (!rstn)
        bus_data_oe |-> !bus_data_out) else $error("ack not low");
    enable_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !en_pin |-> !reg_on && !bus_data_oe && fault_alert_line_n) else $error("enable low");
    fault_bits_a: assert property (@(posedge clk_sys) disable iff (!rstn || !en_pin)
        !fault_alert_line_n |-> status.status_byte[`PMC_CML_BIT]
        && status.status_word[`PMC_CML_BIT] && status.status_mfr[`PMC_MFR_OTP_BIT])
        else $error("alert without fault bits");
    page_step_a: assert property (@(posedge clk_sys) disable iff (!rstn || !en_pin)
        $changed(nvm_page) |-> nvm_page == $past(nvm_page) + 2'h1) else $error("page skip");
    load_first_a: assert property (@(posedge clk_sys) disable iff (!rstn || !en_pin)
        nvm_rd |-> !bus_data_oe) else $error("ack during load");
    bus_busy_a: assert property (@(posedge clk_sys) disable iff (!rstn || !en_pin)
        bus_data_oe |-> !bus_free) else $error("free while acking");
    free_delay_a: assert property (@(posedge clk_sys) disable iff (!rstn || !en_pin)
        $rose(bus_free) |-> low_q >= 9'h0eb) else $error("free too early");
    vset_busy_a: assert property (@(posedge clk_sys) disable iff (!rstn || !en_pin)
        $changed(vcfg) |-> !bus_free) else $error("setting changed off bus");
endmodule

// ---- pmc_master.sv ----
// management-bus master model: clock, framing and bytes
`timescale 1ns/1ns
module pmc_master (
    output logic scl,
    output logic sda_o,
    input wire logic sda
);
    // ********
    // bus sequences, clock idles high
    // ********
    initial begin
        scl = 1'b1;
        sda_o = 1'b1;
    end
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #20 sda_o = b[i];
            #20 scl = 1'b1;
            #40 scl = 1'b0;
        end
        #20 sda_o = 1'b1;
        #20 scl = 1'b1;
        #20 ack = !sda;
        #20 scl = 1'b0;
    endtask
    task automatic write(input logic [6:0] a, input logic [7:0] r, d, output logic [2:0] k);
        #20 sda_o = 1'b1;
        #20 scl = 1'b1;
        #20 sda_o = 1'b0;
        #20 scl = 1'b0;
        send({a, 1'b0}, k[2]);
        send(r, k[1]);
        send(d, k[0]);
        #20 sda_o = 1'b0;
        #20 scl = 1'b1;
        #20 sda_o = 1'b1;
    endtask
endmodule

// ---- pmbus_slave_otp_crc_ctrl_bench.sv ----
// self-checking bench for the management-bus slave
`timescale 1ns/1ns
`include "pmc_defines.svh"
module pmbus_slave_otp_crc_ctrl_bench;
    import pmc_pkg::*;
    logic clk_sys = 1'b0, rstn = 1'b0, en_pin = 1'b1, uvlo_ok = 1'b1;
    logic nvm_done = 1'b0, nvm_crc_ok = 1'b0, scl, sda_o;
    logic bus_data_out, bus_data_oe, nvm_rd, fault_alert_line_n, reg_on, bus_free;
    logic [2:0] addr_strap = 3'h0, acks;
    logic [1:0] nvm_page, top_page;
    pmc_vcfg_t vcfg;
    pmc_status_t status;
    int bad, gap, reads, mismatches, compares;
    wire sda = sda_o & !(bus_data_oe && !bus_data_out);
    pmc_top #(.PAGES(4)) dut (.clk_sys, .rstn, .en_pin, .uvlo_ok, .addr_strap, .bus_clk(scl),
        .bus_data_in(sda), .bus_data_out, .bus_data_oe, .nvm_rd, .nvm_page, .nvm_done,
        .nvm_crc_ok, .nvm_avail_n(2'h0), .vcfg, .status, .fault_alert_line_n, .reg_on, .bus_free);
    pmc_master m (.scl, .sda_o, .sda);
    // ********
    // clock, memory responder, checks
    // ********
    initial forever #10 clk_sys = !clk_sys;
    always @(posedge clk_sys) begin
        gap <= (nvm_rd && !nvm_done) ? gap + 1 : 0;
        nvm_done <= 1'b0;
        if (gap == 8) begin
            nvm_done <= 1'b1;
            nvm_crc_ok <= (bad == 0);
            bad <= (bad > 0) ? bad - 1 : 0;
            reads <= reads + 1;
            if (nvm_page > top_page) top_page <= nvm_page;
        end
    end
    task automatic chk(input string n, input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic do_reset(input int n);
        int q;
        @(posedge clk_sys);
        rstn <= 1'b0;
        bad <= n;
        reads <= 0;
        top_page <= 2'h0;
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (8) @(posedge clk_sys);
        q = 0;
        for (int i = 0; i < 600 && q < 4; i++) begin
            @(posedge clk_sys);
            q = nvm_rd ? 0 : q + 1;
        end
    endtask
    task automatic t_load();
        do_reset(2);
        chk("reads", 8'h03, reads[7:0]);
        chk("page", 8'h00, {6'h0, top_page});
        chk("alert", 8'h01, {7'h0, fault_alert_line_n});
        chk("div", `PMC_VSET_DEFAULT & 8'h0f, {4'h0, vcfg.div_code});
        $display("load test done");
    endtask
    task automatic t_fail();
        do_reset(12);
        chk("reads", 8'h0c, reads[7:0]);
        chk("page", 8'h03, {6'h0, top_page});
        chk("alert", 8'h00, {7'h0, fault_alert_line_n});
        chk("cml", 8'h02, status.status_byte & 8'h02);
        chk("mfr", 8'h01, {7'h0, status.status_mfr[0]});
        $display("fail test done");
    endtask
    task automatic t_refuse();
        addr_strap <= 3'h3;
        do_reset(0);
        m.write(7'h25, `PMC_VSET_REG, 8'h4f, acks);
        chk("nack", 8'h00, {5'h0, acks});
        m.write(7'h24, 8'h22, 8'h4e, acks);
        repeat (10) @(posedge clk_sys);
        chk("acks", 8'h07, {5'h0, acks});
        chk("div", 8'h02, {4'h0, vcfg.div_code});
        chk("busy", 8'h00, {7'h0, bus_free});
        repeat (240) @(posedge clk_sys);
        chk("free", 8'h01, {7'h0, bus_free});
        $display("refuse test done");
    endtask
    task automatic t_strap();
        for (int s = 0; s < 7; s++) begin
            addr_strap <= s[2:0];
            do_reset(0);
            m.write(`PMC_ADDR_BASE + s[6:0], `PMC_VSET_REG, {4'h4, s[3:0] + 4'h1}, acks);
            repeat (10) @(posedge clk_sys);
            chk("acks", 8'h07, {5'h0, acks});
            chk("div", {4'h0, s[3:0] + 4'h1}, {4'h0, vcfg.div_code});
            chk("vref", 8'h02, {4'h0, vcfg.vref_code});
        end
        $display("strap test done");
    endtask
    task automatic t_enable();
        en_pin <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("reg_on", 8'h00, {7'h0, reg_on});
        chk("div", 8'h02, {4'h0, vcfg.div_code});
        uvlo_ok <= 1'b0;
        en_pin <= 1'b1;
        repeat (20) @(posedge clk_sys);
        chk("lockout", 8'h00, {6'h0, reg_on, nvm_rd});
        uvlo_ok <= 1'b1;
        repeat (300) @(posedge clk_sys);
        chk("reg_on", 8'h01, {7'h0, reg_on});
        $display("enable test done");
    endtask
    initial begin
        #1000000;
        mismatches++;
        conclude();
    end
    initial begin
        t_load();
        t_fail();
        t_refuse();
        t_strap();
        t_enable();
        conclude();
    end
endmodule
bind pmc_top pmc_sva chk (.clk_sys, .rstn, .en_pin, .bus_clk, .bus_data_out, .bus_data_oe,
    .nvm_rd, .nvm_page, .vcfg, .status, .fault_alert_line_n, .reg_on, .bus_free);
